// ===== pistb_map.vh
`ifndef PISTB_MAP_VH
`define PISTB_MAP_VH

// ==========================================
// Register offsets (byte addresses on APB)
// ==========================================
`define PISTB_OFF_PSC_CTRL      8'h00
`define PISTB_OFF_TB0_CTRL      8'h04
`define PISTB_OFF_TB1_CTRL      8'h08
`define PISTB_OFF_IRQ_EN        8'h0C
`define PISTB_OFF_IRQ_FLAG      8'h10
`define PISTB_OFF_TMR_GROUP     8'h14
`define PISTB_OFF_CORE_STAT     8'h18

// ==========================================
// Prescaler control fields
// ==========================================
`define PISTB_PSC_EN_BIT        2
`define PISTB_PSC_SEL_HI        1
`define PISTB_PSC_SEL_LO        0
`define PISTB_PSC_SEL_SYS       2'b00
`define PISTB_PSC_SEL_SYS4      2'b01
`define PISTB_PSC_RESET         3'h0
`define PISTB_SYS_DIV           4

// ==========================================
// Time base control fields
// ==========================================
`define PISTB_TB_RUN_BIT        7
`define PISTB_TB_DIV_HI         2
`define PISTB_TB_DIV_LO         0
`define PISTB_TB_RESET          4'h0
`define PISTB_TB_MIN_EXP        8
`define PISTB_TB_CNT_W          15

// ==========================================
// Interrupt enable register bits
// ==========================================
`define PISTB_EN_GLOBAL         0
`define PISTB_EN_CONV           1
`define PISTB_EN_EEPROM         2
`define PISTB_EN_TB0            3
`define PISTB_EN_TB1            4
`define PISTB_EN_SHARED         5
`define PISTB_EN_SERIAL         6
`define PISTB_EN_RESET          7'h00

// ==========================================
// Flag register bits, also vector numbers
// ==========================================
`define PISTB_VEC_CONV          0
`define PISTB_VEC_SHARED        1
`define PISTB_VEC_EEPROM        2
`define PISTB_VEC_TB0           3
`define PISTB_VEC_TB1           4
`define PISTB_VEC_SERIAL        5
`define PISTB_NUM_SRC           6
`define PISTB_FLAG_RESET        6'h00

// ==========================================
// Timer group register: flags 7:4, enables 3:0
// ==========================================
`define PISTB_TMR_FLAG_LO       4
`define PISTB_TMR_RESET         8'h00

`endif

// ===== pistb_tbdiv.v
`timescale 1ns/1ps

// ==========================================
// Time base divider: one per time base
// ==========================================
module pistb_tbdiv #(
    parameter CNT_W   = 15,
    parameter MIN_EXP = 8
) (
    input  wire       clk,
    input  wire       reset,
    input  wire       psc_tick,
    input  wire       run,
    input  wire [2:0] div_sel,
    output reg        overflow
);

    // Free counter of prescaler ticks
    reg  [CNT_W-1:0] count;
    // Mask of the low bits that must all be ones
    wire [CNT_W-1:0] limit_mask;
    wire             at_limit;

    // Ratio 2^(MIN_EXP+sel); the mask spans that many bits
    assign limit_mask = ({CNT_W{1'b1}} >> (CNT_W - MIN_EXP - div_sel));
    assign at_limit   = ((count & limit_mask) == limit_mask);

    // ==========================================
    // Counter and overflow pulse
    // ==========================================
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            count    <= {CNT_W{1'b0}};
            overflow <= 1'b0;
        end else if (!run) begin
            // Stopped: restart from zero so the first period is whole
            count    <= {CNT_W{1'b0}};
            overflow <= 1'b0;
        end else begin
            overflow <= psc_tick & at_limit;
            if (psc_tick) begin
                count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule

// ===== pistb_top.v
`timescale 1ns/1ps
`include "pistb_map.vh"

module pistb_top (
    input  wire        clk,
    input  wire        reset,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Source events, one-cycle pulses
    input  wire        adc_done,
    input  wire        eeprom_write_end,
    input  wire [1:0]  timer_match_a,
    input  wire [1:0]  timer_match_p,
    input  wire        serial_byte_done,
    input  wire        serial_addr_match,
    input  wire        serial_bus_timeout,
    input  wire        sub_clock_tick,
    // Core sequencer side
    input  wire        stack_full,
    input  wire        vector_taken,
    input  wire        interrupt_return,
    output reg         irq_request,
    output reg  [2:0]  irq_vector,
    output reg         wakeup
);

    // ==========================================
    // Registers
    // ==========================================
    reg  [2:0] prescaler_control;    // Enable and source select
    reg  [7:0] time_base_0_control;  // Run bit and ratio
    reg  [7:0] time_base_1_control;
    reg  [6:0] irq_enable;           // Global and source enables
    reg  [5:0] irq_flag;             // Request flags per vector
    reg  [7:0] timer_group;          // Timer flags and enables
    reg  [1:0] sys_div_count;        // System clock divide by four
    reg        sys_div_tick;
    reg  [5:0] flag_prev;            // For rising-edge wake-up
    reg  [3:0] tmr_flag_prev;

    // Convenience names for enables
    wire       global_interrupt_enable = irq_enable[`PISTB_EN_GLOBAL];
    wire       converter_irq_enable    = irq_enable[`PISTB_EN_CONV];
    wire       eeprom_irq_enable       = irq_enable[`PISTB_EN_EEPROM];
    wire       time_base0_irq_enable   = irq_enable[`PISTB_EN_TB0];
    wire       time_base1_irq_enable   = irq_enable[`PISTB_EN_TB1];
    wire       shared_group_enable     = irq_enable[`PISTB_EN_SHARED];
    wire       serial_iface_irq_enable = irq_enable[`PISTB_EN_SERIAL];

    // Prescaler fields
    wire       prescaler_clock_enable  = prescaler_control[`PISTB_PSC_EN_BIT];
    wire [1:0] prescaler_source_select =
        prescaler_control[`PISTB_PSC_SEL_HI:`PISTB_PSC_SEL_LO];

    // Timer group fields: bits 3:0 enables, 7:4 flags
    wire [3:0] tmr_enable = timer_group[3:0];
    wire [3:0] tmr_flag   = timer_group[7:4];

    // ==========================================
    // APB decode
    // ==========================================
    wire       apb_setup  = psel & ~penable;
    wire       apb_access = psel & penable & pready;
    wire       apb_write  = apb_access & pwrite;
    wire       hit_psc    = (paddr == `PISTB_OFF_PSC_CTRL);
    wire       hit_tb0    = (paddr == `PISTB_OFF_TB0_CTRL);
    wire       hit_tb1    = (paddr == `PISTB_OFF_TB1_CTRL);
    wire       hit_en     = (paddr == `PISTB_OFF_IRQ_EN);
    wire       hit_flag   = (paddr == `PISTB_OFF_IRQ_FLAG);
    wire       hit_tmr    = (paddr == `PISTB_OFF_TMR_GROUP);
    wire       hit_stat   = (paddr == `PISTB_OFF_CORE_STAT);
    wire       hit_any    = hit_psc | hit_tb0 | hit_tb1 | hit_en
                          | hit_flag | hit_tmr | hit_stat;

    // ==========================================
    // Prescaler tick selection
    // ==========================================
    reg        prescaler_clock;      // One-cycle enable at the chosen rate
    wire       tb0_overflow;
    wire       tb1_overflow;

    // Divide-by-four enable for the middle source
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sys_div_count <= 2'b00;
            sys_div_tick  <= 1'b0;
        end else begin
            sys_div_count <= sys_div_count + 2'b01;
            sys_div_tick  <= (sys_div_count == (`PISTB_SYS_DIV - 1));
        end
    end

    // Source mux, gated by the prescaler enable
    always @* begin
        if (!prescaler_clock_enable) begin
            prescaler_clock = 1'b0;
        end else if (prescaler_source_select == `PISTB_PSC_SEL_SYS) begin
            prescaler_clock = 1'b1;
        end else if (prescaler_source_select == `PISTB_PSC_SEL_SYS4) begin
            prescaler_clock = sys_div_tick;
        end else begin
            // Sub clock arrives as an enable pulse from outside
            prescaler_clock = sub_clock_tick;
        end
    end

    // ==========================================
    // Time base dividers
    // ==========================================
    // ratio field per base
    pistb_tbdiv #(
        .CNT_W   (`PISTB_TB_CNT_W),
        .MIN_EXP (`PISTB_TB_MIN_EXP)
    ) u_tb0 (
        .clk      (clk),
        .reset    (reset),
        .psc_tick (prescaler_clock),
        .run      (time_base_0_control[`PISTB_TB_RUN_BIT]),
        .div_sel  (time_base_0_control[`PISTB_TB_DIV_HI:`PISTB_TB_DIV_LO]),
        .overflow (tb0_overflow)
    );

    pistb_tbdiv #(
        .CNT_W   (`PISTB_TB_CNT_W),
        .MIN_EXP (`PISTB_TB_MIN_EXP)
    ) u_tb1 (
        .clk      (clk),
        .reset    (reset),
        .psc_tick (prescaler_clock),
        .run      (time_base_1_control[`PISTB_TB_RUN_BIT]),
        .div_sel  (time_base_1_control[`PISTB_TB_DIV_HI:`PISTB_TB_DIV_LO]),
        .overflow (tb1_overflow)
    );

    // ==========================================
    // Flag set, service clear and software write
    // ==========================================
    wire [3:0] tmr_event = {timer_match_a[1], timer_match_p[1],
                            timer_match_a[0], timer_match_p[0]};
    reg  [5:0] set_flag;             // Hardware sets this cycle
    reg  [5:0] svc_clear;            // Clear from a taken vector
    reg  [5:0] next_irq_flag;
    reg  [3:0] next_tmr_flag;

    always @* begin
        set_flag = 6'h00;
        set_flag[`PISTB_VEC_CONV]   = adc_done;
        set_flag[`PISTB_VEC_SHARED] = |tmr_event;
        set_flag[`PISTB_VEC_EEPROM] = eeprom_write_end;
        set_flag[`PISTB_VEC_TB0]    = tb0_overflow;
        set_flag[`PISTB_VEC_TB1]    = tb1_overflow;
        set_flag[`PISTB_VEC_SERIAL] = serial_byte_done | serial_addr_match
                                    | serial_bus_timeout;
        // Service clears only the flag of the vector taken
        svc_clear = 6'h00;
        if (vector_taken && irq_request) begin
            svc_clear[irq_vector] = 1'b1;
        end
        // Software writes replace the value; hardware set wins
        next_irq_flag = irq_flag & ~svc_clear;
        if (apb_write && hit_flag) begin
            next_irq_flag = pwdata[5:0];
        end
        next_irq_flag = next_irq_flag | set_flag;
        next_tmr_flag = tmr_flag;
        if (apb_write && hit_tmr) begin
            next_tmr_flag = pwdata[7:4];
        end
        next_tmr_flag = next_tmr_flag | tmr_event;
    end

    // ==========================================
    // Pending request and priority
    // ==========================================
    reg  [5:0] pend;                 // Flag and source enable both set; shared also needs an enabled timer flag
    reg        next_irq_request;
    reg  [2:0] next_irq_vector;
    integer    i;

    always @* begin
        pend = 6'h00;
        pend[`PISTB_VEC_CONV]   = irq_flag[`PISTB_VEC_CONV]
                                & converter_irq_enable;
        pend[`PISTB_VEC_SHARED] = irq_flag[`PISTB_VEC_SHARED]
                                & shared_group_enable
                                & (|(tmr_flag & tmr_enable));
        pend[`PISTB_VEC_EEPROM] = irq_flag[`PISTB_VEC_EEPROM]
                                & eeprom_irq_enable;
        pend[`PISTB_VEC_TB0]    = irq_flag[`PISTB_VEC_TB0]
                                & time_base0_irq_enable;
        pend[`PISTB_VEC_TB1]    = irq_flag[`PISTB_VEC_TB1]
                                & time_base1_irq_enable;
        pend[`PISTB_VEC_SERIAL] = irq_flag[`PISTB_VEC_SERIAL]
                                & serial_iface_irq_enable;
        // Lowest index wins; scan from the top down
        next_irq_vector = 3'd0;
        for (i = `PISTB_NUM_SRC - 1; i >= 0; i = i - 1) begin
            if (pend[i]) begin
                next_irq_vector = i[2:0];
            end
        end
        // stack full holds request
        // Dropped in the taking cycle so one request is never taken twice
        next_irq_request = global_interrupt_enable & ~stack_full
                         & (|pend) & ~(vector_taken & irq_request);
    end

    // ==========================================
    // Register file and sequencer state
    // ==========================================
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            prescaler_control   <= `PISTB_PSC_RESET;
            time_base_0_control <= {`PISTB_TB_RESET, `PISTB_TB_RESET};
            time_base_1_control <= {`PISTB_TB_RESET, `PISTB_TB_RESET};
            irq_enable          <= `PISTB_EN_RESET;
            irq_flag            <= `PISTB_FLAG_RESET;
            timer_group         <= `PISTB_TMR_RESET;
            irq_request         <= 1'b0;
            irq_vector          <= 3'd0;
        end else begin
            irq_flag            <= next_irq_flag;
            timer_group[7:4]    <= next_tmr_flag;
            irq_request         <= next_irq_request;
            irq_vector          <= next_irq_vector;
            if (apb_write && hit_psc) begin
                prescaler_control <= pwdata[2:0];
            end
            // Only the run bit and ratio field are stored
            if (apb_write && hit_tb0) begin
                time_base_0_control <= {pwdata[7], 4'h0, pwdata[2:0]};
            end
            if (apb_write && hit_tb1) begin
                time_base_1_control <= {pwdata[7], 4'h0, pwdata[2:0]};
            end
            if (apb_write && hit_tmr) begin
                timer_group[3:0] <= pwdata[3:0];
            end
            // Global enable: software, then service clear, then return
            if (apb_write && hit_en) begin
                irq_enable <= pwdata[6:0];
            end
            if (vector_taken && irq_request) begin
                irq_enable[`PISTB_EN_GLOBAL] <= 1'b0;
            end
            if (interrupt_return) begin
                irq_enable[`PISTB_EN_GLOBAL] <= 1'b1;
            end
        end
    end

    // ==========================================
    // Wake-up on any flag rising
    // ==========================================
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            flag_prev     <= `PISTB_FLAG_RESET;
            tmr_flag_prev <= 4'h0;
            wakeup        <= 1'b0;
        end else begin
            flag_prev     <= irq_flag;
            tmr_flag_prev <= tmr_flag;
            wakeup        <= (|(irq_flag & ~flag_prev))
                           | (|(tmr_flag & ~tmr_flag_prev));
        end
    end

    // ==========================================
    // APB answer: one wait-free access phase
    // ==========================================
    reg  [31:0] read_mux;

    // Read data selection; unused bits read as zero
    always @* begin
        read_mux = 32'h0000_0000;
        if (hit_psc) begin
            read_mux[2:0] = prescaler_control;
        end else if (hit_tb0) begin
            read_mux[7:0] = time_base_0_control;
        end else if (hit_tb1) begin
            read_mux[7:0] = time_base_1_control;
        end else if (hit_en) begin
            read_mux[6:0] = irq_enable;
        end else if (hit_flag) begin
            read_mux[5:0] = irq_flag;
        end else if (hit_tmr) begin
            read_mux[7:0] = timer_group;
        end else if (hit_stat) begin
            // Core-facing state for software debug
            read_mux[4:0] = {stack_full, irq_vector, irq_request};
        end
    end

    // Ready rises in the access phase and drops after it
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apb_setup;
            // Unmapped address: error, write dropped, read zero
            pslverr <= apb_setup & ~hit_any;
            if (apb_setup && !pwrite) begin
                prdata <= read_mux;
            end else if (apb_access) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

endmodule

// ===== pistb_core_model.sv
`timescale 1ns/1ps

// ==========================================
// Core sequencer model
// ==========================================
module pistb_core_model (
    input  logic       clk,
    input  logic       reset,
    input  logic       irq_request,
    input  logic       use_int_ret,
    input  logic [7:0] ret_wait,
    output logic       vector_taken,
    output logic       interrupt_return
);
    logic [7:0] busy_cnt;  // Cycles left in the service routine

    // Take one vector, return after ret_wait cycles
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            vector_taken     <= 1'h0;
            interrupt_return <= 1'h0;
            busy_cnt         <= 8'h0;
        end else begin
            // No take while busy, so one pulse per request
            vector_taken     <= irq_request & ~vector_taken & (busy_cnt == 8'h0);
            interrupt_return <= 1'h0;
            if (vector_taken & irq_request) begin
                busy_cnt <= ret_wait;
            end else if (busy_cnt != 8'h0) begin
                busy_cnt <= busy_cnt - 8'h1;
                // A plain return gives no pulse
                if (busy_cnt == 8'h1) begin
                    interrupt_return <= use_int_ret;
                end
            end
        end
    end
endmodule

// ===== pistb_chk_assertions.sv
`timescale 1ns/1ps

// ==========================================
// Port checker
// ==========================================
module pistb_chk (
    input logic        clk,
    input logic        reset,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        stack_full,
    input logic        vector_taken,
    input logic        interrupt_return,
    input logic        irq_request,
    input logic [2:0]  irq_vector
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // ==========================================
    // Core side
    // ==========================================
    AST_STACK_BLOCK: assert property (stack_full |=> !irq_request)
        else $error("request while stack full");
    AST_SERVICE_DROP: assert property (
        irq_request && vector_taken && !interrupt_return && !psel |=> !irq_request)
        else $error("request kept after service");
    // Global enable stays off until a return pulse or a bus write
    AST_PLAIN_RET: assert property (
        irq_request && vector_taken && !interrupt_return ##1
        (!interrupt_return && !psel) [*3] |=> !irq_request)
        else $error("request without return");
    AST_VEC_RANGE: assert property (irq_request |-> irq_vector <= 3'h5)
        else $error("vector out of range");

    // ==========================================
    // Register bus
    // ==========================================
    AST_APB_READY: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_IDLE_QUIET: assert property (!psel |=> !pready && !pslverr)
        else $error("answer without select");
    // Unmapped means past the last word or not word aligned
    AST_ERR_UNMAPPED: assert property (psel && penable |->
        pslverr == (paddr > 8'h18 || paddr[1:0] != 2'b00))
        else $error("error flag wrong for address");
    AST_ERR_READ_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
endmodule

bind pistb_top pistb_chk pistb_chk_inst (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stack_full(stack_full), .vector_taken(vector_taken),
    .interrupt_return(interrupt_return), .irq_request(irq_request), .irq_vector(irq_vector)
);

// ===== tb.sv
`timescale 1ns/1ps

module tb;
    // ==========================================
    // Signals
    // ==========================================
    logic        clk = 1'h0, reset = 1'h1;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, irq_request, wakeup, vector_taken, interrupt_return;
    logic [2:0]  irq_vector;
    logic [8:0]  ev = 9'h0;               // Source event pulses
    logic        sub_tick = 1'h0;         // Sub clock stand-in
    logic        stack_full = 1'h0, use_int_ret = 1'h1;
    logic [7:0]  ret_wait = 8'h14;
    int          errors = 0, checks = 0, cyc = 0, wakes = 0;

    always #2 clk = ~clk;
    // Cycle count, sub clock every fourth cycle, wake-up count
    always @(posedge clk) begin
        cyc      <= cyc + 1;
        sub_tick <= (cyc % 4 == 3);
        if (wakeup === 1'h1) begin
            wakes <= wakes + 1;
        end
    end

    pistb_top pistb_top_inst (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .adc_done(ev[0]), .eeprom_write_end(ev[1]), .timer_match_a(ev[3:2]),
        .timer_match_p(ev[5:4]), .serial_byte_done(ev[6]), .serial_addr_match(ev[7]),
        .serial_bus_timeout(ev[8]), .sub_clock_tick(sub_tick), .stack_full(stack_full),
        .vector_taken(vector_taken), .interrupt_return(interrupt_return),
        .irq_request(irq_request), .irq_vector(irq_vector), .wakeup(wakeup));
    pistb_core_model pistb_core_model_inst (
        .clk(clk), .reset(reset), .irq_request(irq_request), .use_int_ret(use_int_ret),
        .ret_wait(ret_wait), .vector_taken(vector_taken), .interrupt_return(interrupt_return));

    // ==========================================
    // Shared tasks
    // ==========================================
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // One transfer; request held until ready is sampled
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (n >= 50) errors++;
        r = prdata;
        e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'h1, a, d, r, e);
    endtask

    // Read, compare, and check the refusal flag against the map
    task rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'h0, a, 32'h0, r, e);
        chk(r, x);
        chk({31'h0, e}, {31'h0, a > 8'h18});
    endtask

    task pulse(input int b);
        @(posedge clk);
        ev[b] <= 1'h1;
        @(posedge clk);
        ev <= 9'h0;
    endtask

    task wait_req(output logic ok);
        int n;
        ok = 1'h0;
        for (n = 0; n < 5000 && !ok; n++) begin
            @(posedge clk);
            ok = (irq_request === 1'h1);
        end
        chk(ok, 1);
    endtask

    // ==========================================
    // Scenarios
    // ==========================================
    task t_regs;
        logic [7:0]  offs [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
        logic [31:0] msk [8] = '{32'h7, 32'h87, 32'h87, 32'h7F, 32'h3F, 32'hFF, 32'h0, 32'h0};
        int i;
        for (i = 0; i < 8; i++) rd(offs[i], 32'h0);
        for (i = 0; i < 8; i++) begin
            wr(offs[i], 32'hFFFF_FFFF);
            rd(offs[i], msk[i]);
            wr(offs[i], 32'h0);
        end
    endtask

    task t_direct(input logic int_ret);
        int          bit_of [5] = '{0, 1, 6, 7, 8};
        logic [31:0] en_of [5] = '{32'h02, 32'h04, 32'h40, 32'h40, 32'h40};
        logic [31:0] vec_of [5] = '{32'h0, 32'h2, 32'h5, 32'h5, 32'h5};
        int i, w;
        logic ok;
        use_int_ret <= int_ret;
        ret_wait <= 8'h14;
        for (i = 0; i < 5; i++) begin
            wr(8'h0C, en_of[i] | 32'h1);
            w = wakes;
            pulse(bit_of[i]);
            wait_req(ok);
            chk(irq_vector, vec_of[i]);
            repeat (3) @(posedge clk);
            chk(wakes - w, 1);
            rd(8'h10, 32'h0);
            rd(8'h0C, en_of[i]);
            repeat (25) @(posedge clk);
            rd(8'h0C, en_of[i] | {31'h0, int_ret});
        end
    endtask

    task t_shared;
        int          bit_of [4] = '{2, 3, 4, 5};
        logic [31:0] fl_of [4] = '{32'h20, 32'h80, 32'h10, 32'h40};
        int i;
        logic ok;
        wr(8'h0C, 32'h21);
        wr(8'h14, 32'h0F);
        for (i = 0; i < 4; i++) begin
            pulse(bit_of[i]);
            wait_req(ok);
            chk(irq_vector, 32'h1);
            repeat (3) @(posedge clk);
            rd(8'h10, 32'h0);
            rd(8'h14, fl_of[i] | 32'h0F);
            wr(8'h14, 32'h0F);
            repeat (25) @(posedge clk);
        end
        wr(8'h14, 32'h0);
        pulse(2);
        repeat (10) @(posedge clk);
        chk(irq_request, 0);
        rd(8'h10, 32'h02);
        rd(8'h14, 32'h20);
        wr(8'h14, 32'h0);
        wr(8'h10, 32'h0);
    endtask

    task t_stack;
        logic ok;
        wr(8'h0C, 32'h03);
        stack_full <= 1'h1;
        pulse(0);
        repeat (10) @(posedge clk);
        chk(irq_request, 0);
        stack_full <= 1'h0;
        wait_req(ok);
        repeat (25) @(posedge clk);
    endtask

    task t_gated;
        int i;
        wr(8'h0C, 32'h09);
        wr(8'h04, 32'h80);
        for (i = 0; i < 2; i++) begin
            repeat (600) @(posedge clk);
            chk(irq_request, 0);
            wr(8'h00, 32'h04);
            wr(8'h04, 32'h0);
        end
        wr(8'h00, 32'h0);
    endtask

    // Measures the spacing of two time base requests
    task t_period(input logic [31:0] psc, input logic [7:0] off, input logic [31:0] code,
                  input logic [31:0] vec, input int exp);
        int t0;
        logic ok;
        ret_wait <= 8'h02;
        wr(8'h0C, (vec == 32'h3) ? 32'h09 : 32'h11);
        wr(8'h00, psc);
        wr(off, 32'h80 | code);
        wait_req(ok);
        chk(irq_vector, vec);
        t0 = cyc;
        repeat (3) @(posedge clk);
        wait_req(ok);
        chk(cyc - t0, exp);
        wr(off, 32'h0);
        wr(8'h00, 32'h0);
        wr(8'h10, 32'h0);
        wr(8'h0C, 32'h0);
    endtask

    task tally_and_finish;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'h0;
        t_regs;
        t_direct(1'h1);
        t_shared;
        t_stack;
        t_gated;
        t_period(32'h04, 8'h04, 32'h0, 32'h3, 256);
        t_period(32'h04, 8'h04, 32'h1, 32'h3, 512);
        t_period(32'h04, 8'h08, 32'h3, 32'h4, 2048);
        t_period(32'h04, 8'h08, 32'h2, 32'h4, 1024);
        t_period(32'h05, 8'h04, 32'h0, 32'h3, 1024);
        t_period(32'h06, 8'h08, 32'h0, 32'h4, 1024);
        t_period(32'h07, 8'h04, 32'h0, 32'h3, 1024);
        t_direct(1'h0);
        tally_and_finish;
    end

    // Hang guard
    initial begin
        #200000;
        errors++;
        tally_and_finish;
    end
endmodule
